/* File: logic/fcr_report.sv */
//Function
// - IF device: reference point default 100
// - RF device: reference point default 75
// - Sample rate in Hz, 64 bits, two words
// - Binary point right of bit 20
// - Fraction bits of sample rate zero
// - 64-bit femtosecond timestamp adjustment field
// - Timestamp adjustment is two's-complement signed
// - 64-bit buffer size in bytes
// - Buffer size is unsigned binary
// - Top sixteen bits of level word reserved
// - Eight upper level bits below reserved
// - Status high nibble extends level to 12
// - Level is averaged occupancy, designer-chosen
// - Low status nibble: four separate indicators
// - Indicators cover previous to present report
// - Overflow bit set after any overflow
// - Nearly-full bit set on threshold crossing; the code sets it whenever the averaged level is at or above thr_nf_ff
// - Underflow bit set on buffer underflow
// - Second indicator word flags buffer group
//
// Added by the designer: the address map and the Avalon-MM register port.
module fcr_report
	import fcr_pkg::*;
(
	// Clock and reset
	input  wire logic          clk_sys,
	input  wire logic          reset,
	// Avalon-MM slave
	input  wire fcr_avm_req_t  avm_req,
	output logic [31:0]        avm_readdata,
	output logic               avm_waitrequest,
	// Buffer monitor, same clock
	input  wire logic [LVL_W-1:0] buf_level,
	input  wire logic          buf_overflow,
	input  wire logic          buf_underflow,
	// Report issue strobe
	input  wire logic          pkt_issue,
	// Report fields
	output fcr_fields_t        fields,
	output logic               fields_valid
);

	fcr_bus_st_t         bus_st_ff;
	logic                wait_ff;
	logic [31:0]         rdata_ff;
	logic [CTRL_W-1:0]   ctrl_ff;
	logic [31:0]         refpt_ff;
	logic [RATE_INT_W-1:0] rate_ff;
	logic [63:0]         tsadj_ff;
	logic [63:0]         bsize_ff;
	logic [LVL_W-1:0]    thr_nf_ff;
	logic [LVL_W-1:0]    thr_ne_ff;
	logic [ACC_W-1:0]    acc_ff;
	logic [FLAG_W-1:0]   flags_ff;
	logic [31:0]         last_ff;
	fcr_fields_t         fld_ff;
	logic                fvalid_ff;

	logic                bus_req;
	logic                wr_take;
	logic [ACC_W-1:0]    nxt_acc;
	logic [LVL_W-1:0]    avg_lvl;
	logic [FLAG_W-1:0]   evt;
	logic [31:0]         nxt_lvl_word;
	logic [31:0]         ref_sel;

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// Packs level and indicators into the report word
	function automatic logic [31:0] lvl_word(
		input logic [LVL_W-1:0]  lvl,
		input logic [FLAG_W-1:0] flg
	);
		return {{RSV_W{1'b0}}, lvl, flg};
	endfunction

	// Write strobe for one register offset
	function automatic logic wr_hit(
		input logic              take,
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs
	);
		return take && addr == ofs;
	endfunction

	assign bus_req = avm_req.read | avm_req.write;
	assign wr_take = avm_req.write && (bus_st_ff == ST_ACK);

	// Bus handshake: one wait cycle, then a single ack cycle
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bus_st_ff <= ST_IDLE;
			wait_ff   <= 1'b1;
		end else begin
			unique case (bus_st_ff)
				ST_IDLE: begin
					if (bus_req) begin
						bus_st_ff <= ST_ACK;
						wait_ff   <= 1'b0;
					end
				end
				ST_ACK: begin
					bus_st_ff <= ST_IDLE;
					wait_ff   <= 1'b1;
				end
			endcase
		end
	end

	// Read data latched while waitrequest is still high
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rdata_ff <= 32'h0000_0000;
		end else if (bus_st_ff == ST_IDLE && avm_req.read) begin
			unique case (avm_req.address)
				OFS_CTRL:     rdata_ff <= 32'(ctrl_ff);
				OFS_REFPT:    rdata_ff <= refpt_ff;
				OFS_RATE_LO:  rdata_ff <= rate_ff[31:0];
				OFS_RATE_HI:  rdata_ff <= 32'(rate_ff[RATE_INT_W-1:32]);
				OFS_TSADJ_LO: rdata_ff <= tsadj_ff[31:0];
				OFS_TSADJ_HI: rdata_ff <= tsadj_ff[63:32];
				OFS_BSIZE_LO: rdata_ff <= bsize_ff[31:0];
				OFS_BSIZE_HI: rdata_ff <= bsize_ff[63:32];
				OFS_THRESH:   rdata_ff <= {4'h0, thr_nf_ff, 4'h0, thr_ne_ff};
				OFS_STATUS:   rdata_ff <= lvl_word(avg_lvl, flags_ff);
				OFS_LAST:     rdata_ff <= last_ff;
				default:      rdata_ff <= 32'h0000_0000;
			endcase
		end
	end

	// Control: IF/RF select, reference override, averaging shift
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_hit(wr_take, avm_req.address, OFS_CTRL)) begin
			ctrl_ff <= CTRL_W'(be_merge(32'(ctrl_ff), avm_req.writedata,
				avm_req.byteenable));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			refpt_ff <= REFPT_IF;
		end else if (wr_hit(wr_take, avm_req.address, OFS_REFPT)) begin
			refpt_ff <= be_merge(refpt_ff, avm_req.writedata, avm_req.byteenable);
		end
	end

	// Only whole hertz is stored; the fraction never exists in a flop
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rate_ff <= '0;
		end else if (wr_hit(wr_take, avm_req.address, OFS_RATE_LO)) begin
			rate_ff[31:0] <= be_merge(rate_ff[31:0], avm_req.writedata,
				avm_req.byteenable);
		end else if (wr_hit(wr_take, avm_req.address, OFS_RATE_HI)) begin
			rate_ff[RATE_INT_W-1:32] <= RATE_HI_W'(be_merge(
				32'(rate_ff[RATE_INT_W-1:32]), avm_req.writedata,
				avm_req.byteenable));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			tsadj_ff <= '0;
		end else if (wr_hit(wr_take, avm_req.address, OFS_TSADJ_LO)) begin
			tsadj_ff[31:0] <= be_merge(tsadj_ff[31:0], avm_req.writedata,
				avm_req.byteenable);
		end else if (wr_hit(wr_take, avm_req.address, OFS_TSADJ_HI)) begin
			tsadj_ff[63:32] <= be_merge(tsadj_ff[63:32], avm_req.writedata,
				avm_req.byteenable);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			bsize_ff <= '0;
		end else if (wr_hit(wr_take, avm_req.address, OFS_BSIZE_LO)) begin
			bsize_ff[31:0] <= be_merge(bsize_ff[31:0], avm_req.writedata,
				avm_req.byteenable);
		end else if (wr_hit(wr_take, avm_req.address, OFS_BSIZE_HI)) begin
			bsize_ff[63:32] <= be_merge(bsize_ff[63:32], avm_req.writedata,
				avm_req.byteenable);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			thr_nf_ff <= THR_NF_RST;
			thr_ne_ff <= THR_NE_RST;
		end else if (wr_hit(wr_take, avm_req.address, OFS_THRESH)) begin
			if (avm_req.byteenable[0]) begin
				thr_ne_ff[7:0] <= avm_req.writedata[THR_NE_LO +: 8];
			end
			if (avm_req.byteenable[1]) begin
				thr_ne_ff[11:8] <= avm_req.writedata[THR_NE_LO+8 +: 4];
			end
			if (avm_req.byteenable[2]) begin
				thr_nf_ff[7:0] <= avm_req.writedata[THR_NF_LO +: 8];
			end
			if (avm_req.byteenable[3]) begin
				thr_nf_ff[11:8] <= avm_req.writedata[THR_NF_LO+8 +: 4];
			end
		end
	end

	// Exponential average, weight 2^-shift; fraction bits keep small steps
	always_comb begin
		logic signed [ACC_W+1:0] diff;
		logic signed [ACC_W+1:0] step;
		diff = $signed({2'b00, buf_level, {LVL_FRAC_W{1'b0}}})
			- $signed({2'b00, acc_ff});
		step = diff >>> ctrl_ff[CTRL_SHIFT_LO +: CTRL_SHIFT_W];
		if (diff != '0 && step == '0) begin
			step = (diff > 0) ? (ACC_W+2)'(1) : -(ACC_W+2)'(1);
		end
		nxt_acc = ACC_W'($signed({2'b00, acc_ff}) + step);
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			acc_ff <= '0;
		end else begin
			acc_ff <= nxt_acc;
		end
	end

	assign avg_lvl = acc_ff[ACC_W-1:LVL_FRAC_W];

	// Events seen this cycle
	always_comb begin
		evt              = '0;
		evt[FLG_OVF]     = buf_overflow;
		evt[FLG_NFULL]   = avg_lvl >= thr_nf_ff;
		evt[FLG_NEMPTY]  = avg_lvl <= thr_ne_ff;
		evt[FLG_UNF]     = buf_underflow;
	end

	// Sticky per interval; an event in the issue cycle opens the next one
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			flags_ff <= '0;
		end else if (pkt_issue) begin
			flags_ff <= evt;
		end else begin
			flags_ff <= flags_ff | evt;
		end
	end

	assign nxt_lvl_word = lvl_word(avg_lvl, flags_ff | evt);

	// Override wins; otherwise the analog interface picks the default
	always_comb begin
		if (ctrl_ff[CTRL_OVR_BIT]) begin
			ref_sel = refpt_ff;
		end else if (ctrl_ff[CTRL_RF_BIT]) begin
			ref_sel = REFPT_RF;
		end else begin
			ref_sel = REFPT_IF;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			last_ff <= '0;
		end else if (pkt_issue) begin
			last_ff <= nxt_lvl_word;
		end
	end

	// Snapshot of the fields, frozen for the whole report
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fld_ff <= '0;
		end else if (pkt_issue) begin
			fld_ff.ref_point    <= ref_sel;
			fld_ff.sample_rate  <= {rate_ff, {RATE_FRAC_W{1'b0}}};
			fld_ff.ts_adj       <= $signed(tsadj_ff);
			fld_ff.buf_size     <= bsize_ff;
			fld_ff.level_status <= nxt_lvl_word;
			fld_ff.cif1         <= 32'(1) << CIF1_BUF_BIT;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			fvalid_ff <= 1'b0;
		end else if (pkt_issue) begin
			fvalid_ff <= 1'b1;
		end
	end

	assign avm_readdata    = rdata_ff;
	assign avm_waitrequest = wait_ff;
	assign fields          = fld_ff;
	assign fields_valid    = fvalid_ff;

endmodule

/* File: logic/fcr_pkg.sv */
package fcr_pkg;

	// Register byte offsets on the Avalon-MM slave
	localparam int          ADDR_W       = 8;
	localparam logic [7:0]  OFS_CTRL     = 8'h00;
	localparam logic [7:0]  OFS_REFPT    = 8'h04;
	localparam logic [7:0]  OFS_RATE_LO  = 8'h08;
	localparam logic [7:0]  OFS_RATE_HI  = 8'h0C;
	localparam logic [7:0]  OFS_TSADJ_LO = 8'h10;
	localparam logic [7:0]  OFS_TSADJ_HI = 8'h14;
	localparam logic [7:0]  OFS_BSIZE_LO = 8'h18;
	localparam logic [7:0]  OFS_BSIZE_HI = 8'h1C;
	localparam logic [7:0]  OFS_THRESH   = 8'h20;
	localparam logic [7:0]  OFS_STATUS   = 8'h24;
	localparam logic [7:0]  OFS_LAST     = 8'h28;

	// Control register fields
	localparam int          CTRL_RF_BIT   = 0;
	localparam int          CTRL_OVR_BIT  = 1;
	localparam int          CTRL_SHIFT_LO = 2;
	localparam int          CTRL_SHIFT_W  = 3;
	localparam int          CTRL_W        = 5;
	localparam logic [4:0]  CTRL_RST      = 5'h10;

	// Reference point defaults
	localparam logic [31:0] REFPT_IF = 32'h0000_0064;
	localparam logic [31:0] REFPT_RF = 32'h0000_004B;

	// Sample rate: integer hertz above a 20-bit zero fraction
	localparam int RATE_FRAC_W = 20;
	localparam int RATE_INT_W  = 64 - RATE_FRAC_W;
	localparam int RATE_HI_W   = RATE_INT_W - 32;

	// Buffer level and status word
	localparam int LVL_W       = 12;
	localparam int LVL_FRAC_W  = 4;
	localparam int ACC_W       = LVL_W + LVL_FRAC_W;
	localparam int RSV_W       = 16;
	localparam int FLAG_W      = 4;
	localparam int FLG_OVF     = 3;
	localparam int FLG_NFULL   = 2;
	localparam int FLG_NEMPTY  = 1;
	localparam int FLG_UNF     = 0;
	localparam int THR_NF_LO   = 16;
	localparam int THR_NE_LO   = 0;
	localparam logic [11:0] THR_NF_RST = 12'hE00;
	localparam logic [11:0] THR_NE_RST = 12'h200;

	// Presence bit for the three-word buffer size group
	localparam int CIF1_BUF_BIT = 1;

	typedef struct packed {
		logic                read;
		logic                write;
		logic [ADDR_W-1:0]   address;
		logic [31:0]         writedata;
		logic [3:0]          byteenable;
	} fcr_avm_req_t;

	typedef struct packed {
		logic [31:0]         ref_point;
		logic [63:0]         sample_rate;
		logic signed [63:0]  ts_adj;
		logic [63:0]         buf_size;
		logic [31:0]         level_status;
		logic [31:0]         cif1;
	} fcr_fields_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b10
	} fcr_bus_st_t;

endpackage

/* File: dv/fcr_report_assertions.sv */
module fcr_report_assertions
	import fcr_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        reset,
	// Monitor and strobe
	input wire logic        buf_overflow,
	input wire logic        buf_underflow,
	input wire logic        pkt_issue,
	// Report
	input wire fcr_fields_t fields,
	input wire logic        fields_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);
	logic [LVL_W-1:0] lvl;
	assign lvl = fields.level_status[15:4];

	AST_RESV: assert property (fields.level_status[31:16] == 16'h0000)
		else $error("reserved bits of level word not zero");
	AST_FRAC: assert property (fields.sample_rate[19:0] == 20'h00000)
		else $error("sample rate fraction not zero");
	AST_CIF1: assert property (fields_valid |-> fields.cif1 == (32'h1 << CIF1_BUF_BIT))
		else $error("buffer group presence bit wrong");
	AST_OVF: assert property (buf_overflow ##1 pkt_issue |=> fields.level_status[FLG_OVF])
		else $error("overflow not reported");
	AST_UNF: assert property (buf_underflow ##1 pkt_issue |=> fields.level_status[FLG_UNF])
		else $error("underflow not reported");
	AST_CLR: assert property ((pkt_issue && !buf_overflow) ##1
		(pkt_issue && !buf_overflow) |=> !fields.level_status[FLG_OVF])
		else $error("overflow flag not cleared on issue");
	AST_HOLD: assert property (!pkt_issue |=> $stable(fields))
		else $error("fields changed without issue");
	AST_VALID: assert property (pkt_issue |=> fields_valid)
		else $error("fields_valid missing after issue");
	AST_NF: assert property (pkt_issue ##1 (lvl >= THR_NF_RST)
		|-> fields.level_status[FLG_NFULL])
		else $error("nearly full not reported");
	AST_NE: assert property (pkt_issue ##1 (lvl <= THR_NE_RST)
		|-> fields.level_status[FLG_NEMPTY])
		else $error("nearly empty not reported");

	cover property (buf_overflow ##1 pkt_issue);
	cover property (pkt_issue ##1 fields.level_status[FLG_NFULL]);
	cover property (pkt_issue ##1 pkt_issue);
endmodule

/* File: dv/fcr_ctl_model.sv */
module fcr_ctl_model
	import fcr_pkg::*;
(
	// Report from the sender
	input  wire fcr_fields_t      fields,
	input  wire logic             fields_valid,
	// Decoded view
	output logic [RATE_INT_W-1:0] rx_hz,
	output logic signed [63:0]    rx_ts,
	output logic [63:0]           rx_bsize,
	output logic [LVL_W-1:0]      rx_lvl,
	output logic [FLAG_W-1:0]     rx_flg
);
	timeunit 1ns;
	timeprecision 1ps;
	// Rate, timestamp and size are not trusted before the first report lands; level and flags pass straight through
	always_comb begin
		rx_hz    = fields_valid ? fields.sample_rate[63:RATE_FRAC_W] : '0;
		rx_ts    = fields_valid ? fields.ts_adj : '0;
		rx_bsize = fields_valid ? fields.buf_size : '0;
		rx_lvl   = {fields.level_status[15:8], fields.level_status[7:4]};
		rx_flg   = fields.level_status[3:0];
	end
endmodule

/* File: dv/tb_top.sv */
module tb_top
	import fcr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  clk_sys, reset, buf_overflow, buf_underflow, pkt_issue;
	fcr_avm_req_t          avm_req;
	logic [31:0]           avm_readdata, rd;
	logic                  avm_waitrequest, fields_valid;
	logic [LVL_W-1:0]      buf_level, rx_lvl;
	fcr_fields_t           fields;
	logic [RATE_INT_W-1:0] rx_hz;
	logic signed [63:0]    rx_ts;
	logic [63:0]           rx_bsize;
	logic [FLAG_W-1:0]     rx_flg;
	int                    miscompares = 0, n_tests = 0, cycles = 0;

	fcr_report dut_u (.clk_sys(clk_sys), .reset(reset), .avm_req(avm_req),
		.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest),
		.buf_level(buf_level), .buf_overflow(buf_overflow), .buf_underflow(buf_underflow),
		.pkt_issue(pkt_issue), .fields(fields), .fields_valid(fields_valid));
	fcr_ctl_model ctl_u (.fields(fields), .fields_valid(fields_valid), .rx_hz(rx_hz),
		.rx_ts(rx_ts), .rx_bsize(rx_bsize), .rx_lvl(rx_lvl), .rx_flg(rx_flg));

	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	task automatic results();
		$display("Tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avm_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'hF};
		do @(posedge clk_sys); while (avm_waitrequest !== 1'b0);
		rd = avm_readdata;
		avm_req <= '0;
	endtask

	// Optional event one cycle ahead of n back-to-back issue pulses
	task automatic rep(input logic ov, input logic un, input int n);
		@(posedge clk_sys);
		buf_overflow <= ov;
		buf_underflow <= un;
		@(posedge clk_sys);
		{buf_overflow, buf_underflow} <= 2'b00;
		pkt_issue <= 1'b1;
		repeat (n) @(posedge clk_sys);
		pkt_issue <= 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic settle(input logic [LVL_W-1:0] lv);
		@(posedge clk_sys);
		buf_level <= lv;
		repeat (400) @(posedge clk_sys);
		rep(1'b0, 1'b0, 1);
		rep(1'b0, 1'b0, 1);
	endtask

	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			miscompares++;
			results();
		end
	end

	initial begin
		{avm_req, buf_level, buf_overflow, buf_underflow, pkt_issue} = '0;
		reset = 1'b1;
		repeat (5) @(posedge clk_sys);
		reset <= 1'b0;
		bus(1'b0, OFS_REFPT, 32'h0); chk(rd, REFPT_IF);
		chk(fields_valid, 1'b0);
		bus(1'b0, 8'h2C, 32'h0); chk(rd, 32'h0);
		bus(1'b0, OFS_THRESH, 32'h0); chk(rd, 32'h0E00_0200);
		rep(1'b0, 1'b0, 1); chk(fields.ref_point, REFPT_IF);
		chk(fields.level_status, 32'h0000_0002);
		chk(fields.cif1, 32'h1 << CIF1_BUF_BIT);
		chk(fields_valid, 1'b1);
		bus(1'b1, OFS_CTRL, 32'h0000_0011);
		bus(1'b1, OFS_RATE_LO, 32'h89AB_CDEF);
		bus(1'b1, OFS_RATE_HI, 32'h0000_0ABC);
		bus(1'b1, OFS_TSADJ_LO, 32'hFFFF_FFFB);
		bus(1'b1, OFS_TSADJ_HI, 32'hFFFF_FFFF);
		bus(1'b1, OFS_BSIZE_LO, 32'h0000_0001);
		bus(1'b1, OFS_BSIZE_HI, 32'h8000_0000);
		rep(1'b0, 1'b0, 2); chk(fields.ref_point, REFPT_RF);
		chk(fields.sample_rate, {12'hABC, 32'h89AB_CDEF, 20'h00000});
		chk(rx_hz, 44'hABC_89AB_CDEF);
		chk(rx_ts, 64'hFFFF_FFFF_FFFF_FFFB);
		chk(64'(rx_ts < 0), 64'h1);
		chk(rx_bsize, 64'h8000_0000_0000_0001);
		bus(1'b1, OFS_REFPT, 32'h0000_1234);
		bus(1'b1, OFS_CTRL, 32'h0000_0013);
		rep(1'b0, 1'b0, 1); chk(fields.ref_point, 32'h0000_1234);
		rep(1'b1, 1'b0, 1); chk(rx_flg, 4'hA);
		rep(1'b0, 1'b0, 1); chk(rx_flg, 4'h2);
		rep(1'b0, 1'b1, 1); chk(rx_flg, 4'h3);
		settle(12'hFFF); chk(fields.level_status, 32'h0000_FFF4);
		chk(rx_lvl, 12'hFFF);
		bus(1'b0, OFS_LAST, 32'h0); chk(rd, 32'h0000_FFF4);
		settle(12'h000); chk(fields.level_status, 32'h0000_0002);
		bus(1'b0, OFS_STATUS, 32'h0); chk(rd, 32'h0000_0002);
		results();
	end
endmodule

bind fcr_report fcr_report_assertions chk_u (.clk_sys(clk_sys), .reset(reset),
	.buf_overflow(buf_overflow), .buf_underflow(buf_underflow), .pkt_issue(pkt_issue),
	.fields(fields), .fields_valid(fields_valid));
